/* File: hw/ecg_sample_fifo.sv */
// ECG sample buffer read over the SPI slave port, with fill-level and overrun flags.
// Assumes samples and clear commands come from clk_sys logic; SPI pins are asynchronous.
`timescale 1ns/100ps
`default_nettype none
`include "esf_map.svh"

//Behaviour
//- Hold ECG results in a 32-entry, 24-bit circular buffer with separate pointers.
//- Write pointer advances internally as samples arrive; host cannot move it.
//- Single read consumes the entry on the 32nd SCLK rising edge.
//- Burst read consumes an entry on edges 32 plus n times 24, n up to 31.
//- A consumed entry is never presented again.
//- Fill flag rises when unread count reaches the 5-bit threshold meaning 1 to 32.
//- A write finding the buffer full is overrun: flag and tag show it.
//- Resync or fifo-clear command empties the buffer after an overrun.
//- Host writes to the read locations change nothing.
//- Readable at 0x20 burst and 0x21 single; 18-bit sample on top, two tags.
//- Sample tag in bits 5..3: valid, fast, and their last-available forms.
//- Reading an empty buffer returns sample tag 110.
//- After overrun every read returns sample tag 111 until cleared.
//- Pacing tag in bits 2..0; 111 means no linked pacing event.
module ecg_sample_fifo #(
    parameter int DEPTH = `ESF_DEPTH,
    parameter int WIDTH = `ESF_WORD_BITS
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Sample source
    input  wire logic        sampleValid,
    input  wire logic [17:0] sampleData,
    input  wire logic        sampleFast,
    input  wire logic [2:0]  pacingPointerTag,
    output logic             sampleReady,
    // Commands and configuration
    input  wire logic        fifoClearCmd,
    input  wire logic        channelResyncCommand,
    input  wire logic [4:0]  ecgFillIrqLevel,
    // Status
    output logic             ecgFillIrqFlag,
    output logic             ecgOverrunFlag,
    // SPI slave pins
    input  wire logic        spiSclk,
    input  wire logic        spiCsN,
    input  wire logic        spiSdi,
    output logic             spiSdoOut,
    output logic             spiSdoOe
);
    // Threshold field covers 1..32 and the word layout is fixed
    if (DEPTH > 32 || WIDTH != 24)
    begin : g_chk
        $error("ecg_sample_fifo: DEPTH above 32 or WIDTH other than 24");
    end

    localparam int LW = $clog2(DEPTH) + 1;

    esf_pkg::esf_spi_state_t state_r;
    esf_pkg::esf_spi_state_t state_nxt;

    logic          sclkMeta_r, sclkSync_r, sclkLast_r;
    logic          csNMeta_r, csNSync_r;
    logic          sdiMeta_r, sdiSync_r;
    logic [2:0]    cmdCnt_r;
    logic [6:0]    cmdSh_r;
    logic          burst_r;
    logic [4:0]    wordBit_r;
    logic [4:0]    wordNum_r;
    logic          loadReq_r;
    logic          wordValid_r;
    logic [23:0]   dataSh_r;
    logic          sdoOut_r;
    logic          sdoOe_r;
    logic          overrun_r;
    logic          fillFlag_r;
    logic [9:0]    edgeCnt_r;
    logic [LW-1:0] fifoLevel;
    logic [23:0]   fifoData;
    logic          fifoOutValid;

    // Pin synchronisers; the first stage is never read by logic
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {sclkMeta_r, sclkSync_r, sclkLast_r} <= 3'h0;
            {csNMeta_r, csNSync_r}               <= 2'h3;
            {sdiMeta_r, sdiSync_r}               <= 2'h0;
        end
        else
        begin
            {sclkMeta_r, sclkSync_r, sclkLast_r} <= {spiSclk, sclkMeta_r, sclkSync_r};
            {csNMeta_r, csNSync_r}               <= {spiCsN, csNMeta_r};
            {sdiMeta_r, sdiSync_r}               <= {spiSdi, sdiMeta_r};
        end
    end

    // Edge and command decode
    wire sclkRise   = sclkSync_r && !sclkLast_r;
    wire sclkFall   = !sclkSync_r && sclkLast_r;
    wire csActive   = !csNSync_r;
    wire cmdDone    = (state_r == esf_pkg::ESF_CMD) && sclkRise && (cmdCnt_r == `ESF_CMD_LAST_BIT);
    wire addrBurst  = (cmdSh_r == `ESF_ADDR_BURST);
    wire addrSingle = (cmdSh_r == `ESF_ADDR_SINGLE);
    wire readOk     = sdiSync_r && (addrBurst || addrSingle);
    wire wordEnd    = (state_r == esf_pkg::ESF_DATA) && sclkRise && (wordBit_r == `ESF_WORD_LAST_BIT);
    wire moreWords  = burst_r && (wordNum_r != `ESF_BURST_LAST_N);
    wire popNow     = wordEnd && wordValid_r;
    wire clr        = fifoClearCmd || channelResyncCommand;
    wire sampleWr   = sampleValid && sampleReady && !clr;
    wire overSet    = sampleValid && !sampleReady && !clr;

    // Outgoing word: tag chosen by buffer state at load time
    wire [2:0] liveTag  = {1'b0, (fifoLevel == LW'(1)), fifoData[`ESF_SAMPLE_TAG_LSB]};
    wire [2:0] headTag  = overrun_r     ? esf_pkg::ESF_TAG_OVERRUN :
                          !fifoOutValid ? esf_pkg::ESF_TAG_EMPTY   :
                          liveTag;
    wire [2:0] headPtag = fifoOutValid ? fifoData[`ESF_PACING_POINTER_TAG_MSB:`ESF_PACING_POINTER_TAG_LSB] : `ESF_PACING_POINTER_TAG_NONE;
    wire [23:0] headWord = {fifoData[`ESF_SAMPLE_MSB:`ESF_SAMPLE_LSB], headTag, headPtag};

    // Storage; write side driven only by the sample source
    esf_buffer #(
        .WIDTH (WIDTH),
        .DEPTH (DEPTH)
    ) u_buf (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .clr      (clr),
        .inValid  (sampleValid),
        .inData   ({sampleData, 2'h0, sampleFast, pacingPointerTag}),
        .inReady  (sampleReady),
        .outValid (fifoOutValid),
        .outData  (fifoData),
        .outReady (popNow),
        .level    (fifoLevel)
    );

    // Transaction sequencing; chip select high aborts anything
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            esf_pkg::ESF_IDLE:
                if (csActive)
                    state_nxt = esf_pkg::ESF_CMD;
            esf_pkg::ESF_CMD:
                if (cmdDone)
                    state_nxt = readOk ? esf_pkg::ESF_DATA : esf_pkg::ESF_SKIP;
            esf_pkg::ESF_DATA:
                if (wordEnd && !moreWords)
                    state_nxt = esf_pkg::ESF_SKIP;
            esf_pkg::ESF_SKIP:
                state_nxt = state_r;
        endcase
        if (!csActive)
            state_nxt = esf_pkg::ESF_IDLE;
    end

    // Command shift, bit and word counters
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r   <= esf_pkg::ESF_IDLE;
            cmdCnt_r  <= 3'h0;
            cmdSh_r   <= 7'h00;
            burst_r   <= 1'b0;
            wordBit_r <= 5'h00;
            wordNum_r <= 5'h00;
            edgeCnt_r <= 10'h000;
            loadReq_r <= 1'b0;
        end
        else
        begin
            state_r   <= state_nxt;
            loadReq_r <= (cmdDone && readOk) || (wordEnd && moreWords);
            if (state_r == esf_pkg::ESF_IDLE)
            begin
                cmdCnt_r  <= 3'h0;
                wordBit_r <= 5'h00;
                wordNum_r <= 5'h00;
                edgeCnt_r <= 10'h000;
            end
            else if (sclkRise)
            begin
                edgeCnt_r <= edgeCnt_r + 10'h001;
                if (state_r == esf_pkg::ESF_CMD)
                begin
                    cmdCnt_r <= cmdCnt_r + 3'h1;
                    burst_r  <= addrBurst;
                    if (cmdCnt_r != `ESF_CMD_LAST_BIT)
                        cmdSh_r <= {cmdSh_r[5:0], sdiSync_r};
                end
                if (state_r == esf_pkg::ESF_DATA)
                begin
                    wordBit_r <= wordEnd ? 5'h00 : wordBit_r + 5'h01;
                    if (wordEnd)
                        wordNum_r <= wordNum_r + 5'h01;
                end
            end
        end
    end

    // Output shifter: load one cycle after the pop so the new head is seen
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dataSh_r    <= 24'h00_0000;
            wordValid_r <= 1'b0;
            sdoOut_r    <= 1'b0;
            sdoOe_r     <= 1'b0;
        end
        else
        begin
            // Held until the fall after the last rise; the host samples bit 0 late in that phase
            sdoOe_r <= csActive && ((state_nxt == esf_pkg::ESF_DATA) || (sdoOe_r && !sclkFall));
            if (loadReq_r)
            begin
                dataSh_r    <= headWord;
                wordValid_r <= fifoOutValid;
            end
            else if (sclkFall && state_r == esf_pkg::ESF_DATA)
            begin
                sdoOut_r <= dataSh_r[23];
                dataSh_r <= {dataSh_r[22:0], 1'b0};
            end
        end
    end

    // Status flags; clear beats a same-cycle refused write, clear cycles cannot overrun
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            overrun_r  <= 1'b0;
            fillFlag_r <= 1'b0;
        end
        else
        begin
            if (overSet)
                overrun_r <= 1'b1;
            else if (clr)
                overrun_r <= 1'b0;
            fillFlag_r <= (6'(fifoLevel) >= (6'(ecgFillIrqLevel) + 6'h01));
        end
    end

    assign ecgFillIrqFlag = fillFlag_r;
    assign ecgOverrunFlag = overrun_r;
    assign spiSdoOut      = sdoOut_r;
    assign spiSdoOe       = sdoOe_r;

    // Checks
    depth_bound_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        fifoLevel <= LW'(DEPTH)) else $error("buffer holds more than its depth");
    write_advance_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sampleWr && !popNow |=> fifoLevel == $past(fifoLevel) + LW'(1)) else $error("write did not advance");
    single_pop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        popNow && !burst_r |-> edgeCnt_r == 10'(`ESF_FIRST_POP_EDGE - 1)) else $error("single pop off edge 32");
    burst_pop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        popNow && burst_r |-> edgeCnt_r >= 10'(`ESF_FIRST_POP_EDGE - 1)
            && (int'(edgeCnt_r) - (`ESF_FIRST_POP_EDGE - 1)) % `ESF_BURST_STRIDE == 0
            && edgeCnt_r <= 10'(`ESF_FIRST_POP_EDGE - 1 + 31 * `ESF_BURST_STRIDE)) else $error("burst pop off grid");
    pop_consumes_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        popNow && !sampleWr && !clr |=> fifoLevel == $past(fifoLevel) - LW'(1)) else $error("pop left entry");
    fill_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ##1 ecgFillIrqFlag == ($past(fifoLevel) > LW'($past(ecgFillIrqLevel)))) else $error("fill flag wrong");
    overrun_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        overSet |=> ecgOverrunFlag) else $error("overrun not flagged");
    clear_empties_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clr |=> fifoLevel == '0 && !ecgOverrunFlag ##1 ecgFillIrqFlag == 1'b0) else $error("clear incomplete");
    write_ignored_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cmdDone && !sdiSync_r && csActive |=> state_r == esf_pkg::ESF_SKIP && !spiSdoOe) else $error("write not ignored");
    empty_tag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        loadReq_r && !fifoOutValid && !overrun_r |=> dataSh_r[5:3] == 3'b110 && dataSh_r[2:0] == 3'b111)
        else $error("empty tag wrong");
    overrun_tag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        loadReq_r && overrun_r |=> dataSh_r[5:3] == 3'b111) else $error("overrun tag wrong");
    last_tag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        loadReq_r && fifoOutValid && !overrun_r |=> dataSh_r[4] == ($past(fifoLevel) == LW'(1))
            && dataSh_r[5] == 1'b0) else $error("last tag wrong");
    last_bit_driven_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        popNow && csActive |=> spiSdoOe) else $error("data line released before last bit");

endmodule

`default_nettype wire

/* File: pkg/esf_map.svh */
// Constants of the ECG sample buffer: SPI addresses, word layout, read timing.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef ESF_MAP_SVH
`define ESF_MAP_SVH

// Buffer geometry
`define ESF_DEPTH          32
`define ESF_WORD_BITS      24

// Read locations, 7-bit SPI register address
`define ESF_ADDR_BURST     7'h20
`define ESF_ADDR_SINGLE    7'h21

// Word layout
`define ESF_SAMPLE_MSB     23
`define ESF_SAMPLE_LSB     6
`define ESF_SAMPLE_TAG_MSB       5
`define ESF_SAMPLE_TAG_LSB       3
`define ESF_PACING_POINTER_TAG_MSB       2
`define ESF_PACING_POINTER_TAG_LSB       0
`define ESF_SAMPLE_TAG_LAST_BIT  4

// Transaction timing in SCLK rising edges
`define ESF_CMD_LAST_BIT   3'h7
`define ESF_WORD_LAST_BIT  5'h17
`define ESF_BURST_LAST_N   5'h1f
`define ESF_FIRST_POP_EDGE 32
`define ESF_BURST_STRIDE   24

// Pacing tag with no linked pacing event
`define ESF_PACING_POINTER_TAG_NONE      3'h7

`endif

/* File: pkg/esf_pkg.sv */
// Types of the ECG sample buffer: serial port states and sample tag codes.
// Assumes nothing of its surroundings.
`default_nettype none

package esf_pkg;

    typedef enum logic [1:0]
    {
        ESF_IDLE = 2'b00,
        ESF_CMD  = 2'b01,
        ESF_DATA = 2'b10,
        ESF_SKIP = 2'b11
    } esf_spi_state_t;

    typedef enum logic [2:0]
    {
        ESF_TAG_VALID      = 3'b000,
        ESF_TAG_FAST       = 3'b001,
        ESF_TAG_VALID_LAST = 3'b010,
        ESF_TAG_FAST_LAST  = 3'b011,
        ESF_TAG_EMPTY      = 3'b110,
        ESF_TAG_OVERRUN    = 3'b111
    } esf_tag_t;

endpackage

`default_nettype wire

/* File: hw/esf_buffer.sv */
// Circular buffer with first-word-fall-through read side and synchronous clear.
// Assumes both sides run on clk_sys; clear wins over a same-cycle write or read.
`timescale 1ns/100ps
`default_nettype none

module esf_buffer #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       rst_n,
    // Control
    input  wire logic                       clr,
    // Fill side
    input  wire logic                       inValid,
    input  wire logic [WIDTH-1:0]           inData,
    output logic                            inReady,
    // Drain side
    output logic                            outValid,
    output logic [WIDTH-1:0]                outData,
    input  wire logic                       outReady,
    // Unread entries
    output logic [$clog2(DEPTH):0]          level
);
    localparam int AW = $clog2(DEPTH);

    // Pointer arithmetic needs a power of two
    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin : g_chk
        $error("esf_buffer: DEPTH must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr_r;
    logic [AW:0]      rdPtr_r;

    // Extra pointer bit tells full from empty
    wire full  = (wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
    wire empty = (wrPtr_r == rdPtr_r);
    wire wrEn  = inValid && !full && !clr;
    wire rdEn  = outReady && !empty && !clr;

    assign inReady  = !full;
    assign outValid = !empty;
    assign outData  = mem[rdPtr_r[AW-1:0]];
    assign level    = wrPtr_r - rdPtr_r;

    // Pointers; write side moves on its own, never from the reader
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
        end
        else if (clr)
        begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
        end
        else
        begin
            if (wrEn)
                wrPtr_r <= wrPtr_r + 1'b1;
            if (rdEn)
                rdPtr_r <= rdPtr_r + 1'b1;
        end
    end

    // Storage has no reset; outData shows stale or unwritten words while empty
    always_ff @(posedge clk_sys)
    begin
        if (wrEn)
            mem[wrPtr_r[AW-1:0]] <= inData;
    end

endmodule

`default_nettype wire

/* File: tb/esf_spi_host.sv */
// Host model: SPI mode 0 master that frames reads and writes to the sample buffer.
// Assumes the bench calls frame() by hierarchy; SCLK stands low between frames.
`timescale 1ns/100ps
`default_nettype none

module esf_spi_host #(
    parameter int HALF = 24
) (
    // SPI pins
    output logic      spiSclk,
    output logic      spiCsN,
    output logic      spiSdi,
    input  wire logic spiSdoOut,
    input  wire logic spiSdoOe
);
    // Words of the last frame, and whether the device drove the data line
    logic [23:0] words [32];
    logic        sawOe;

    initial
    begin
        spiSclk = 1'b0;
        spiCsN = 1'b1;
        spiSdi = 1'b0;
        sawOe = 1'b0;
    end

    // Command byte then n whole words; SDO taken late in the high phase for sync margin
    task automatic frame(input logic [6:0] addr, input logic rd, input int n);
        logic [7:0] cmd;
        cmd = {addr, rd};
        sawOe = 1'b0;
        spiCsN = 1'b0;
        #(HALF);
        for (int b = 0; b < 8 + 24 * n; b++)
        begin
            spiSdi = (b < 8) ? cmd[7 - b] : b[0];
            #(HALF);
            spiSclk = 1'b1;
            #(HALF - 1);
            sawOe = sawOe | spiSdoOe;
            // Undriven line reads inverted, so an early release shows up
            if (b >= 8)
                words[(b - 8) / 24][23 - (b - 8) % 24] = spiSdoOe ? spiSdoOut : ~spiSdoOut;
            #1;
            spiSclk = 1'b0;
        end
        #(HALF);
        spiCsN = 1'b1;
        // Released line shows the opposite level, never a stale bit
        spiSdi = ~spiSdi;
        #(4 * HALF);
    endtask
endmodule

`default_nettype wire

/* File: tb/ecg_sample_fifo_tb.sv */
// Self-checking bench of the ECG sample buffer: pushes samples, reads them over SPI.
// Assumes the host model esf_spi_host; internal assertions live in the design.
`timescale 1ns/100ps
`default_nettype none
`include "esf_map.svh"

module ecg_sample_fifo_tb;
    // Design pins
    logic        clk_sys;
    logic        rst_n;
    logic        sampleValid;
    logic [17:0] sampleData;
    logic        sampleFast;
    logic [2:0]  pacingPointerTag;
    logic        sampleReady;
    logic        fifoClearCmd;
    logic        channelResyncCommand;
    logic [4:0]  ecgFillIrqLevel;
    logic        ecgFillIrqFlag;
    logic        ecgOverrunFlag;
    logic        spiSclk;
    logic        spiCsN;
    logic        spiSdi;
    logic        spiSdoOut;
    logic        spiSdoOe;
    // Reference contents {sample, fast, pacing} and bookkeeping
    logic [21:0] model [$];
    logic        ovf;
    int          errors;
    int          checked;

    ecg_sample_fifo u_ecg_sample_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .sampleValid(sampleValid),
        .sampleData(sampleData),
        .sampleFast(sampleFast),
        .pacingPointerTag(pacingPointerTag),
        .sampleReady(sampleReady),
        .fifoClearCmd(fifoClearCmd),
        .channelResyncCommand(channelResyncCommand),
        .ecgFillIrqLevel(ecgFillIrqLevel),
        .ecgFillIrqFlag(ecgFillIrqFlag),
        .ecgOverrunFlag(ecgOverrunFlag),
        .spiSclk(spiSclk),
        .spiCsN(spiCsN),
        .spiSdi(spiSdi),
        .spiSdoOut(spiSdoOut),
        .spiSdoOe(spiSdoOe)
    );

    esf_spi_host u_esf_spi_host (
        .spiSclk(spiSclk),
        .spiCsN(spiCsN),
        .spiSdi(spiSdi),
        .spiSdoOut(spiSdoOut),
        .spiSdoOe(spiSdoOe)
    );

    // 200 MHz system clock
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic close_out;
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Inputs set after a tick move 1 ns after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Tag is {0, last, fast}: valid, fast and their last-available forms
    function automatic logic [23:0] exp_word(input logic [21:0] e, input logic last);
        exp_word = {e[21:4], 1'b0, last, e[3], e[2:0]};
    endfunction

    // One offered sample; a refused one sets the overrun expectation
    task automatic push(input logic [17:0] d, input logic f, input logic [2:0] p);
        tick(1);
        sampleValid = 1'b1;
        sampleData = d;
        sampleFast = f;
        pacingPointerTag = p;
        if (sampleReady === 1'b1)
            model.push_back({d, f, p});
        else
            ovf = 1'b1;
        tick(1);
        sampleValid = 1'b0;
    endtask

    task automatic pulse(input logic resync);
        tick(1);
        fifoClearCmd = ~resync;
        channelResyncCommand = resync;
        tick(1);
        fifoClearCmd = 1'b0;
        channelResyncCommand = 1'b0;
        model.delete();
        ovf = 1'b0;
        tick(3);
    endtask

    // Read n words; compare each against the reference head, only the sample tag when overrun, both tags when empty
    task automatic rd(input logic [6:0] addr, input int n);
        logic [23:0] w;
        u_esf_spi_host.frame(addr, 1'b1, n);
        check("sdo enable", 24'h00_0001, {23'h00_0000, u_esf_spi_host.sawOe});
        for (int k = 0; k < n; k++)
        begin
            w = u_esf_spi_host.words[k];
            if (ovf)
                check("overrun tag", 24'h00_0007, {21'h00_0000, w[5:3]});
            else if (model.size() == 0)
                check("empty tags", 24'h00_0037, {18'h0_0000, w[5:0]});
            else
                check("word", exp_word(model[0], model.size() == 1), w);
            if (model.size() > 0)
                model.delete(0);
        end
    endtask

    // Hang guard
    initial
    begin
        repeat (60000) @(posedge clk_sys);
        errors++;
        $display("Error watchdog expected finish seen hang");
        close_out();
    end

    initial
    begin
        rst_n = 1'b0;
        sampleValid = 1'b0;
        sampleData = 18'h0_0000;
        sampleFast = 1'b0;
        pacingPointerTag = 3'h7;
        fifoClearCmd = 1'b0;
        channelResyncCommand = 1'b0;
        ecgFillIrqLevel = 5'h03;
        errors = 0;
        checked = 0;
        ovf = 1'b0;
        tick(3);
        rst_n = 1'b1;
        tick(4);
        check("reset state", 24'h00_0004, {21'h00_0000, sampleReady, ecgFillIrqFlag, spiSdoOe});

        // Ignored accesses, then single reads draining to empty
        push(18'h2_5A3C, 1'b0, 3'h5);
        push(18'h1_0F0F, 1'b1, `ESF_PACING_POINTER_TAG_NONE);
        push(18'h3_FFFF, 1'b1, 3'h0);
        u_esf_spi_host.frame(`ESF_ADDR_SINGLE, 1'b0, 1);
        check("write drove sdo", 24'h00_0000, {23'h00_0000, u_esf_spi_host.sawOe});
        u_esf_spi_host.frame(7'h22, 1'b1, 1);
        check("unmapped drove sdo", 24'h00_0000, {23'h00_0000, u_esf_spi_host.sawOe});
        repeat (4) rd(`ESF_ADDR_SINGLE, 1);
        $display("test single reads done");

        // Fill level 3 means four entries
        for (int k = 0; k < 3; k++)
            push(18'(k * 4099), 1'b0, 3'(k));
        tick(3);
        check("fill below", 24'h00_0000, {23'h00_0000, ecgFillIrqFlag});
        push(18'h0_0444, 1'b0, 3'h4);
        tick(3);
        check("fill reached", 24'h00_0001, {23'h00_0000, ecgFillIrqFlag});
        rd(`ESF_ADDR_SINGLE, 1);
        tick(3);
        check("fill dropped", 24'h00_0000, {23'h00_0000, ecgFillIrqFlag});
        rd(`ESF_ADDR_BURST, 3);
        rd(`ESF_ADDR_SINGLE, 1);
        $display("test fill level and burst done");

        // Full buffer, overrun, clear and resync
        ecgFillIrqLevel = 5'h1f;
        for (int k = 0; k < 32; k++)
            push(18'(k * 257), k[0], 3'(k % 6));
        tick(3);
        check("full", 24'h00_0002, {21'h00_0000, sampleReady, ecgFillIrqFlag, ecgOverrunFlag});
        push(18'h1_2345, 1'b0, 3'h1);
        tick(2);
        check("overrun", 24'h00_0001, {23'h00_0000, ecgOverrunFlag});
        rd(`ESF_ADDR_SINGLE, 1);
        rd(`ESF_ADDR_BURST, 2);
        pulse(1'b0);
        check("cleared", 24'h00_0004, {21'h00_0000, sampleReady, ecgFillIrqFlag, ecgOverrunFlag});
        rd(`ESF_ADDR_SINGLE, 1);
        push(18'h0_1111, 1'b0, 3'h2);
        push(18'h0_2222, 1'b1, 3'h3);
        pulse(1'b1);
        rd(`ESF_ADDR_SINGLE, 1);
        push(18'h2_0001, 1'b0, 3'h1);
        rd(`ESF_ADDR_SINGLE, 1);
        $display("test overrun and clear done");
        close_out();
    end
endmodule

`default_nettype wire
